//--- rqs_device.sv
`timescale 1ns/1ps
`default_nettype none
module rqs_device
  import rqs_pkg::*;
#(
  parameter int unsigned P_STEP_BASE_CYC = STEP_BASE_CYC,
  parameter int unsigned P_WAIT_UNIT_CYC = WAIT_UNIT_CYC
)
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Supply monitors, high while above power-off threshold
  input wire logic i_analogue_supply_ok,
  input wire logic i_core_supply_ok,
  // Register link
  rqs_if.dev bus,
  // Reset and sequencer state
  output logic o_por_n,
  output logic o_seq_running,
  // Step writes towards the codec register space
  output logic o_step_wr,
  output logic [7:0] o_step_target,
  output logic [3:0] o_step_field_lsb,
  output logic [2:0] o_step_field_width,
  output logic [7:0] o_step_value,
  // DAC digital control
  output logic [15:0] o_dac_ctrl
);

  // Sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ISSUE = 2'b01,
    SEQ_WAIT = 2'b10
  } rqs_seq_state_t;

  logic [9:0] por_cnt_q;         // Hold counter after supplies good
  logic por_n_q;                 // Internal reset, low active
  logic supplies_ok;             // Both monitors above threshold
  logic wr_ok;                   // Write that is allowed to land
  logic clr;                     // Register reset of any source
  logic sw_reset;                // Write to the identity register
  logic [15:0] seq_ctrl_q;       // Enable and edit index
  logic [15:0] dac_ctrl_q;       // DAC digital control
  logic [5:0] first_step_q;      // Last launch index, for readback
  rqs_step_t steps_q [STEP_COUNT];
  rqs_seq_state_t state_q;
  logic [5:0] idx_q;             // Step being run
  logic [31:0] wait_q;           // Cycles left in current step
  logic [5:0] edit_idx;
  logic launch_wr;
  logic go_req;
  logic abort_req;
  logic [31:0] step_cycles;
  logic [15:0] rd_word;
  logic [15:0] rdata_q;
  logic rvalid_q;
  logic step_wr_q;
  rqs_step_t cur_q;              // Latched step driving the outputs
  rqs_step_t edit_step;

  // Comparator hysteresis lives in the analogue monitors, so a
  // dip above the off thresholds leaves both inputs high here
  assign supplies_ok = i_analogue_supply_ok & i_core_supply_ok;

  // Hold timer restarts on any drop, giving the least period
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst || !supplies_ok)
    begin
      por_cnt_q <= 10'h000;
      por_n_q <= 1'b0;
    end
    else if (por_cnt_q == 10'(POR_CYC - 1))
      por_n_q <= 1'b1;
    else
      por_cnt_q <= por_cnt_q + 10'h001;
  end

  // Writes only land while the internal reset is released
  assign wr_ok = bus.wr & por_n_q;
  // Any value written to offset zero acts as a soft reset
  assign sw_reset = wr_ok & (bus.addr == ADDR_IDENT);
  // Reset or soft reset returns every register to default
  assign clr = i_rst | ~por_n_q | sw_reset;
  assign edit_idx = seq_ctrl_q[5:0];
  // Edit index past the top slot reads back as a dummy, never unknown
  assign edit_step = (edit_idx <= STEP_LAST_IDX) ? steps_q[edit_idx]
    : rqs_mk(DUMMY_TARGET, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0);
  assign launch_wr = wr_ok & (bus.addr == ADDR_SEQ_LAUNCH);
  // A start is refused unless enabled, clocked and in range
  assign go_req = launch_wr & bus.wdata[SEQ_GO_BIT] & ~bus.wdata[SEQ_ABORT_BIT]
    & seq_ctrl_q[SEQ_ENABLE_BIT] & bus.mclk_run & (bus.wdata[5:0] <= STEP_LAST_IDX);
  assign abort_req = launch_wr & bus.wdata[SEQ_ABORT_BIT];
  // Step length: fixed part plus unit scaled by the wait code
  assign step_cycles = 32'(P_STEP_BASE_CYC)
    + (32'(P_WAIT_UNIT_CYC) << steps_q[idx_q].wait_code);

  // Control and DAC registers
  always_ff @(posedge i_ref_clk)
  begin
    if (clr)
    begin
      seq_ctrl_q <= SEQ_CTRL_RST;
      dac_ctrl_q <= DAC_CTRL_RST;
      first_step_q <= 6'h00;
    end
    else if (wr_ok)
    begin
      // Enable and edit index come from the control register
      if (bus.addr == ADDR_SEQ_CTRL)
        seq_ctrl_q <= bus.wdata;
      // Host clearing the DAC register unmutes the DACs
      if (bus.addr == ADDR_DAC_CTRL)
        dac_ctrl_q <= bus.wdata;
      if (bus.addr == ADDR_SEQ_LAUNCH)
        first_step_q <= bus.wdata[5:0];
    end
  end

  // Step store; one generated slot per step
  genvar gi;
  generate
    for (gi = 0; gi < STEP_COUNT; gi++)
    begin : g_step
      always_ff @(posedge i_ref_clk)
      begin
        // Power loss or soft reset reloads factory steps
        if (clr)
          steps_q[gi] <= rqs_default_step(gi);
        // Target word fills address, start and width
        else if (wr_ok && bus.addr == ADDR_STEP_TARGET && edit_idx == 6'(gi))
        begin
          steps_q[gi].target <= bus.wdata[7:0];
          steps_q[gi].lsb <= bus.wdata[FIELD_LSB_POS +: 4];
          steps_q[gi].width <= bus.wdata[FIELD_WIDTH_POS +: 3];
        end
        // Payload word fills value, wait and last flag
        else if (wr_ok && bus.addr == ADDR_STEP_PAYLOAD && edit_idx == 6'(gi))
        begin
          steps_q[gi].value <= bus.wdata[7:0];
          steps_q[gi].wait_code <= bus.wdata[WAIT_CODE_POS +: 4];
          steps_q[gi].last <= bus.wdata[LAST_FLAG_BIT];
        end
      end
    end
  endgenerate

  // Sequencer engine; a new start while busy is ignored
  always_ff @(posedge i_ref_clk)
  begin
    // Supply loss stops the engine on the edge that asserts reset
    if (clr || !supplies_ok)
    begin
      state_q <= SEQ_IDLE;
      idx_q <= 6'h00;
      wait_q <= 32'h0000_0000;
      step_wr_q <= 1'b0;
      cur_q <= rqs_mk(DUMMY_TARGET, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0);
    end
    else
    begin
      step_wr_q <= 1'b0;
      // Abort ends any running sequence at once
      if (abort_req)
        state_q <= SEQ_IDLE;
      else
        unique case (state_q)
          SEQ_IDLE:
          begin
            // Launch index selects start-up or shutdown
            if (go_req)
            begin
              idx_q <= bus.wdata[5:0];
              state_q <= SEQ_ISSUE;
            end
          end
          SEQ_ISSUE:
          begin
            // A dummy target produces no register write
            cur_q <= steps_q[idx_q];
            step_wr_q <= (steps_q[idx_q].target != DUMMY_TARGET);
            wait_q <= step_cycles - 32'h0000_0001;
            state_q <= SEQ_WAIT;
          end
          SEQ_WAIT:
          begin
            // Wait codes set each step's length
            if (wait_q != 32'h0000_0000)
              wait_q <= wait_q - 32'h0000_0001;
            // Stop after a last step or at the top slot
            else if (cur_q.last || idx_q == STEP_LAST_IDX)
              state_q <= SEQ_IDLE;
            else
            begin
              idx_q <= idx_q + 6'h01;
              state_q <= SEQ_ISSUE;
            end
          end
          default: state_q <= SEQ_IDLE;
        endcase
    end
  end

  // Read decode; unmapped offsets read as zero
  assign rd_word =
    (bus.addr == ADDR_IDENT) ? IDENT_VALUE :
    (bus.addr == ADDR_DAC_CTRL) ? dac_ctrl_q :
    (bus.addr == ADDR_SEQ_CTRL) ? seq_ctrl_q :
    (bus.addr == ADDR_STEP_TARGET) ?
      {1'b0, edit_step.width, edit_step.lsb, edit_step.target} :
    (bus.addr == ADDR_STEP_PAYLOAD) ?
      {1'b0, edit_step.last, 2'b00, edit_step.wait_code, edit_step.value} :
    (bus.addr == ADDR_SEQ_LAUNCH) ? {10'h000, first_step_q} :
    // Running flag readback for host polling
    (bus.addr == ADDR_SEQ_STATUS) ? {15'h0000, o_seq_running} :
    16'h0000;

  // Read answer one cycle after the strobe; none while in reset
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst || !por_n_q)
    begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= bus.rd;
      if (bus.rd)
        rdata_q <= rd_word;
    end
  end

  assign bus.rdata = rdata_q;
  assign bus.rvalid = rvalid_q;
  assign o_por_n = por_n_q;
  // High from the cycle after launch until the last step ends
  assign o_seq_running = (state_q != SEQ_IDLE);
  assign o_step_wr = step_wr_q;
  assign o_step_target = cur_q.target;
  assign o_step_field_lsb = cur_q.lsb;
  assign o_step_field_width = cur_q.width;
  assign o_step_value = cur_q.value;
  assign o_dac_ctrl = dac_ctrl_q;

endmodule : rqs_device
`default_nettype wire

//--- rqs_host.sv
`timescale 1ns/1ps
`default_nettype none
module rqs_host
  import rqs_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Command port
  input wire logic i_cmd_valid,
  input wire rqs_cmd_t i_cmd,
  output logic o_cmd_ready,
  output logic o_done,
  // Clocking state towards the system
  output logic o_sys_clock_gate,
  // Register link
  rqs_if.host bus
);

  // Host states
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_WRITE = 3'b001,
    H_POLL = 3'b010,
    H_WAIT_RD = 3'b011,
    H_FINISH = 3'b100
  } rqs_host_state_t;

  rqs_host_state_t state_q;
  rqs_cmd_t cmd_q;               // Command under way
  logic [2:0] op_q;              // Write index in the script
  logic up_q;                    // Start-up or fast start-up completed
  logic clk_on_q;                // Master clock and system clock gate
  logic done_q;
  logic [24:0] op_word;          // {last, addr, data}
  logic accept;

  // Write script per command: {last, offset, value}
  function automatic logic [24:0] host_op(input rqs_cmd_t c, input logic [2:0] n);
    host_op = {1'b1, ADDR_DAC_CTRL, 16'h0000};
    unique case (c)
      CMD_STARTUP:
        // Enable, launch at 0, then unmute
        unique case (n)
          3'd0: host_op = {1'b0, ADDR_SEQ_CTRL, 16'h0100};
          3'd1: host_op = {1'b0, ADDR_SEQ_LAUNCH, 16'h0100};
          default: host_op = {1'b1, ADDR_DAC_CTRL, 16'h0000};
        endcase
      CMD_FAST_STARTUP:
        // Replace slot 11h with a dummy, then launch
        unique case (n)
          3'd0: host_op = {1'b0, ADDR_SEQ_CTRL, 16'h0111};
          3'd1: host_op = {1'b0, ADDR_STEP_TARGET, 16'h00ff};
          3'd2: host_op = {1'b0, ADDR_STEP_PAYLOAD, 16'h0000};
          3'd3: host_op = {1'b0, ADDR_SEQ_LAUNCH, 16'h0100};
          default: host_op = {1'b1, ADDR_DAC_CTRL, 16'h0000};
        endcase
      // Single launch write at index 19h
      CMD_SHUTDOWN: host_op = {1'b1, ADDR_SEQ_LAUNCH, 16'h0119};
      default: host_op = {1'b1, ADDR_DAC_CTRL, 16'h0000};
    endcase
  endfunction : host_op

  assign op_word = host_op(cmd_q, op_q);
  // Shutdown is only taken after a finished start-up
  assign o_cmd_ready = (state_q == H_IDLE);
  assign accept = i_cmd_valid & o_cmd_ready & ((i_cmd != CMD_SHUTDOWN) | up_q);

  // Host procedure engine
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      state_q <= H_IDLE;
      cmd_q <= CMD_STARTUP;
      op_q <= 3'd0;
      up_q <= 1'b0;
      clk_on_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      unique case (state_q)
        H_IDLE:
        begin
          if (accept)
          begin
            cmd_q <= i_cmd;
            op_q <= 3'd0;
            // Clock runs before the first sequencer write
            clk_on_q <= 1'b1;
            state_q <= H_WRITE;
          end
        end
        H_WRITE:
        begin
          // One write per cycle until the script's last entry
          if (op_word[24])
            state_q <= H_POLL;
          else
            op_q <= op_q + 3'd1;
        end
        // Poll the running flag
        H_POLL: state_q <= H_WAIT_RD;
        H_WAIT_RD:
        begin
          if (bus.rvalid)
            state_q <= bus.rdata[RUNNING_BIT] ? H_POLL : H_FINISH;
        end
        H_FINISH:
        begin
          up_q <= (cmd_q != CMD_SHUTDOWN);
          // Clock stops only once shutdown reports idle
          if (cmd_q == CMD_SHUTDOWN)
            clk_on_q <= 1'b0;
          done_q <= 1'b1;
          state_q <= H_IDLE;
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  // Link strobes decoded from the state
  assign bus.wr = (state_q == H_WRITE);
  assign bus.rd = (state_q == H_POLL);
  assign bus.addr = (state_q == H_POLL) ? ADDR_SEQ_STATUS : op_word[23:16];
  assign bus.wdata = op_word[15:0];
  assign bus.mclk_run = clk_on_q;
  assign o_sys_clock_gate = clk_on_q;
  assign o_done = done_q;

endmodule : rqs_host
`default_nettype wire

//--- rqs_if.sv
`timescale 1ns/1ps
`default_nettype none
// Register control link between host and device
interface rqs_if;
  logic wr;            // Write strobe, one cycle
  logic rd;            // Read strobe, one cycle
  logic [7:0] addr;    // Register offset
  logic [15:0] wdata;  // Write data
  logic [15:0] rdata;  // Read data, valid with rvalid
  logic rvalid;        // Read answer, one cycle
  logic mclk_run;      // Host reports master clock running
  modport dev(input wr, rd, addr, wdata, mclk_run, output rdata, rvalid);
  modport host(output wr, rd, addr, wdata, mclk_run, input rdata, rvalid);
endinterface : rqs_if
`default_nettype wire

//--- rqs_pkg.sv
`default_nettype none
package rqs_pkg;
  // Clock period of i_ref_clk
  localparam int CLK_NS = 10;
  // Least power-on reset hold, rounded up to whole cycles
  localparam int POR_HOLD_NS = 9500;
  localparam int POR_CYC = (POR_HOLD_NS + CLK_NS - 1) / CLK_NS;
  // Step timing: fixed part plus a unit scaled by 2^wait_code
  localparam int STEP_BASE_NS = 500000;
  localparam int WAIT_UNIT_NS = 62500;
  localparam int STEP_BASE_CYC = STEP_BASE_NS / CLK_NS;
  localparam int WAIT_UNIT_CYC = WAIT_UNIT_NS / CLK_NS;
  // Register offsets
  localparam logic [7:0] ADDR_IDENT = 8'h00;
  localparam logic [7:0] ADDR_DAC_CTRL = 8'h21;
  localparam logic [7:0] ADDR_SEQ_CTRL = 8'h6c;
  localparam logic [7:0] ADDR_STEP_TARGET = 8'h6d;
  localparam logic [7:0] ADDR_STEP_PAYLOAD = 8'h6e;
  localparam logic [7:0] ADDR_SEQ_LAUNCH = 8'h6f;
  localparam logic [7:0] ADDR_SEQ_STATUS = 8'h70;
  // Field positions
  localparam int SEQ_ENABLE_BIT = 8;
  localparam int SEQ_GO_BIT = 8;
  localparam int SEQ_ABORT_BIT = 9;
  localparam int FIELD_LSB_POS = 8;
  localparam int FIELD_WIDTH_POS = 12;
  localparam int WAIT_CODE_POS = 8;
  localparam int LAST_FLAG_BIT = 14;
  localparam int RUNNING_BIT = 0;
  // Reset values; identity value is arbitrary
  localparam logic [15:0] IDENT_VALUE = 16'h5a3c;
  localparam logic [15:0] DAC_CTRL_RST = 16'h0008;
  localparam logic [15:0] SEQ_CTRL_RST = 16'h0000;
  // Step store geometry
  localparam int STEP_COUNT = 40;
  localparam logic [5:0] STEP_LAST_IDX = 6'h27;
  localparam logic [7:0] DUMMY_TARGET = 8'hff;

  // One stored step
  typedef struct packed {
    logic [7:0] target;
    logic [2:0] width;
    logic [3:0] lsb;
    logic [7:0] value;
    logic [3:0] wait_code;
    logic last;
  } rqs_step_t;

  // Host commands
  typedef enum logic [1:0] {
    CMD_STARTUP = 2'b00,
    CMD_FAST_STARTUP = 2'b01,
    CMD_SHUTDOWN = 2'b10
  } rqs_cmd_t;

  // Build one step
  function automatic rqs_step_t rqs_mk(input logic [7:0] t, input logic [2:0] w,
    input logic [3:0] l, input logic [7:0] v, input logic [3:0] d, input logic e);
    rqs_mk = '{target: t, width: w, lsb: l, value: v, wait_code: d, last: e};
  endfunction : rqs_mk

  // Factory contents of the step store; unlisted slots are dummies
  function automatic rqs_step_t rqs_default_step(input int i);
    unique case (i)
      19: rqs_default_step = rqs_mk(8'h5a, 3'h7, 4'h0, 8'h77, 4'h0, 1'b0);
      20: rqs_default_step = rqs_mk(8'h5e, 3'h7, 4'h0, 8'h77, 4'h0, 1'b0);
      21: rqs_default_step = rqs_mk(8'h5a, 3'h7, 4'h0, 8'hff, 4'h0, 1'b0);
      22: rqs_default_step = rqs_mk(8'h5e, 3'h7, 4'h0, 8'hff, 4'h0, 1'b1);
      25: rqs_default_step = rqs_mk(8'h5e, 3'h7, 4'h0, 8'h77, 4'h0, 1'b0);
      26: rqs_default_step = rqs_mk(8'h5a, 3'h7, 4'h0, 8'h77, 4'h0, 1'b0);
      27: rqs_default_step = rqs_mk(8'h5a, 3'h7, 4'h0, 8'h00, 4'h0, 1'b0);
      28: rqs_default_step = rqs_mk(8'h5e, 3'h7, 4'h0, 8'h00, 4'h0, 1'b0);
      29: rqs_default_step = rqs_mk(8'h43, 3'h3, 4'h0, 8'h00, 4'h0, 1'b0);
      30: rqs_default_step = rqs_mk(8'h62, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0);
      31: rqs_default_step = rqs_mk(8'h12, 3'h1, 4'h2, 8'h00, 4'h0, 1'b0);
      32: rqs_default_step = rqs_mk(8'h16, 3'h0, 4'h1, 8'h00, 4'h0, 1'b0);
      33: rqs_default_step = rqs_mk(8'h0e, 3'h1, 4'h0, 8'h00, 4'h0, 1'b0);
      34: rqs_default_step = rqs_mk(8'h0f, 3'h1, 4'h0, 8'h00, 4'h0, 1'b0);
      35: rqs_default_step = rqs_mk(8'h04, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0);
      36: rqs_default_step = rqs_mk(8'h05, 3'h0, 4'h0, 8'h00, 4'hc, 1'b0);
      37: rqs_default_step = rqs_mk(8'h05, 3'h0, 4'h0, 8'h00, 4'h9, 1'b0);
      38: rqs_default_step = rqs_mk(8'h05, 3'h7, 4'h0, 8'h00, 4'h0, 1'b0);
      39: rqs_default_step = rqs_mk(8'h04, 3'h1, 4'h0, 8'h00, 4'h0, 1'b1);
      default: rqs_default_step = rqs_mk(DUMMY_TARGET, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0);
    endcase
  endfunction : rqs_default_step
endpackage : rqs_pkg
`default_nettype wire

//--- rqs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rqs_sva
  import rqs_pkg::*;
(
  // Clock, reset and supplies
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_analogue_supply_ok,
  input wire logic i_core_supply_ok,
  // Link signals
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic rvalid,
  input wire logic mclk_run,
  // Device outputs
  input wire logic o_por_n,
  input wire logic o_seq_running,
  input wire logic o_step_wr,
  input wire logic [7:0] o_step_target,
  input wire logic [15:0] o_dac_ctrl
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  // Least good-supply run before release, one edge of slack
  localparam logic [10:0] OK_MIN = 11'(POR_CYC - 1);
  // Good-supply cycle count; saturates so a long run cannot wrap
  logic [10:0] ok_cnt_q;
  logic [10:0] ok_cnt_d;
  logic sup_ok;
  assign sup_ok = i_analogue_supply_ok && i_core_supply_ok;
  assign ok_cnt_d = !sup_ok ? 11'h000 : (ok_cnt_q == 11'h7ff) ? ok_cnt_q : ok_cnt_q + 11'h001;

  // Counter register
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      ok_cnt_q <= 11'h000;
    else
      ok_cnt_q <= ok_cnt_d;
  end

  // Host start-up pair, shutdown launch
  sequence s_enable;
    wr && addr == ADDR_SEQ_CTRL && wdata == 16'h0100 && o_por_n;
  endsequence
  sequence s_go_zero;
    wr && addr == ADDR_SEQ_LAUNCH && wdata == 16'h0100 && mclk_run && !o_seq_running;
  endsequence
  sequence s_go_down;
    wr && addr == ADDR_SEQ_LAUNCH && wdata == 16'h0119 && o_por_n && mclk_run && !o_seq_running;
  endsequence

  a_por_hold_min: assert property ($rose(o_por_n) |-> ok_cnt_q >= OK_MIN)
    else $error("reset released too early");
  a_supply_drop: assert property (!sup_ok |-> ##[1:2] !o_por_n)
    else $error("reset not asserted on supply loss");
  a_por_quiet: assert property (!o_por_n |-> !o_seq_running && !o_step_wr)
    else $error("activity while in reset");
  a_read_answer: assert property (rd && o_por_n |=> rvalid)
    else $error("read not answered");
  a_por_no_read: assert property (rd && !o_por_n |=> !rvalid)
    else $error("read answered in reset");
  a_startup_go: assert property (s_enable ##1 s_go_zero |=> o_seq_running)
    else $error("start-up launch did not run");
  a_shutdown_first: assert property (s_go_down |=> o_seq_running ##1
    (o_step_wr && o_step_target == 8'h5e))
    else $error("shutdown did not begin at its first step");
  a_dac_write: assert property (wr && addr == ADDR_DAC_CTRL && o_por_n |=>
    o_dac_ctrl == $past(wdata))
    else $error("dac control not written");
  a_run_hold: assert property ($rose(o_seq_running) |-> o_seq_running [*7])
    else $error("running flag dropped early");
  a_clock_stop: assert property ($fell(mclk_run) |-> !o_seq_running && !$past(o_seq_running))
    else $error("clock stopped while running");
endmodule : rqs_sva
`default_nettype wire

//--- rqs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rqs_tb_top;
  import rqs_pkg::*;
  // Stimulus
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic sup_a = 1'b1;
  logic sup_c = 1'b1;
  logic cmd_valid = 1'b0;
  rqs_cmd_t cmd = CMD_STARTUP;
  // Observed outputs
  wire logic a_por_n, a_run, a_stwr, b_por_n, b_run, b_stwr, h_ready, h_done, h_gate;
  wire logic [7:0] a_tgt, b_tgt, b_val;
  wire logic [3:0] b_lsb;
  wire logic [2:0] b_wid;
  wire logic [15:0] a_dac;
  int n_errors = 0;
  int n_checks = 0;
  logic [7:0] t;
  int i;
  rqs_if bus_a();
  rqs_if bus_b();

  always #5 i_ref_clk = ~i_ref_clk;

  // Host and device joined; short step counts keep the run brief
  rqs_host rqs_host_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cmd_valid(cmd_valid),
    .i_cmd(cmd), .o_cmd_ready(h_ready), .o_done(h_done), .o_sys_clock_gate(h_gate), .bus(bus_a));
  rqs_device #(.P_STEP_BASE_CYC(4), .P_WAIT_UNIT_CYC(2)) rqs_device_inst (.i_ref_clk(i_ref_clk),
    .i_rst(i_rst), .i_analogue_supply_ok(sup_a), .i_core_supply_ok(sup_c), .bus(bus_a),
    .o_por_n(a_por_n), .o_seq_running(a_run), .o_step_wr(a_stwr), .o_step_target(a_tgt),
    .o_step_field_lsb(), .o_step_field_width(), .o_step_value(), .o_dac_ctrl(a_dac));
  // Second device driven by the bench for register and refusal cases
  rqs_device #(.P_STEP_BASE_CYC(4), .P_WAIT_UNIT_CYC(2)) rqs_device_inst_b (.i_ref_clk(i_ref_clk),
    .i_rst(i_rst), .i_analogue_supply_ok(sup_a), .i_core_supply_ok(sup_c), .bus(bus_b),
    .o_por_n(b_por_n), .o_seq_running(b_run), .o_step_wr(b_stwr), .o_step_target(b_tgt),
    .o_step_field_lsb(b_lsb), .o_step_field_width(b_wid), .o_step_value(b_val), .o_dac_ctrl());
  rqs_sva rqs_sva_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_analogue_supply_ok(sup_a),
    .i_core_supply_ok(sup_c), .wr(bus_a.wr), .rd(bus_a.rd), .addr(bus_a.addr),
    .wdata(bus_a.wdata), .rvalid(bus_a.rvalid), .mclk_run(bus_a.mclk_run), .o_por_n(a_por_n),
    .o_seq_running(a_run), .o_step_wr(a_stwr), .o_step_target(a_tgt), .o_dac_ctrl(a_dac));

  // Verdict and end of run
  task automatic complete_run;
    if (n_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic hung;
    n_errors++;
    $display("[FAIL] %0t wait limit reached", $time);
    complete_run();
  endtask : hung

  // One write; a cycle passes before the strobe can rise again
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge i_ref_clk);
    bus_b.wr = 1'b1;
    bus_b.addr = a;
    bus_b.wdata = d;
    @(negedge i_ref_clk);
    bus_b.wr = 1'b0;
    bus_b.wdata = ~d;
  endtask : reg_wr

  // Read answers one cycle after the strobe
  task automatic reg_rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(negedge i_ref_clk);
    bus_b.rd = 1'b1;
    bus_b.addr = a;
    @(negedge i_ref_clk);
    bus_b.rd = 1'b0;
    chk({15'h0000, bus_b.rvalid}, 16'h0001);
    chk(bus_b.rdata, exp);
  endtask : reg_rd_chk

  task automatic wait_step_b(output logic [7:0] tg);
    int k;
    for (k = 0; k < 20000 && b_stwr !== 1'b1; k++)
      @(negedge i_ref_clk);
    if (k == 20000)
      hung();
    tg = b_tgt;
  endtask : wait_step_b

  task automatic wait_idle_b(input int lim);
    int k;
    for (k = 0; k < lim && b_run !== 1'b0; k++)
      @(negedge i_ref_clk);
    chk({15'h0000, b_run}, 16'h0000);
  endtask : wait_idle_b

  task automatic host_cmd(input rqs_cmd_t c, input int lim);
    int k;
    @(negedge i_ref_clk);
    cmd_valid = 1'b1;
    cmd = c;
    @(negedge i_ref_clk);
    cmd_valid = 1'b0;
    for (k = 0; k < lim && h_done !== 1'b1; k++)
      @(negedge i_ref_clk);
    if (k == lim)
      hung();
  endtask : host_cmd

  // Main sequence
  initial
  begin
    bus_b.wr = 1'b0;
    bus_b.rd = 1'b0;
    bus_b.addr = 8'h00;
    bus_b.wdata = 16'h0000;
    bus_b.mclk_run = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    i_rst = 1'b0;
    reg_wr(ADDR_DAC_CTRL, 16'h1234);
    for (i = 0; i < 2000 && a_por_n !== 1'b1; i++)
      @(negedge i_ref_clk);
    chk({15'h0000, i >= POR_CYC - 2 && i < 2000}, 16'h0001);
    reg_rd_chk(ADDR_DAC_CTRL, DAC_CTRL_RST);
    reg_rd_chk(ADDR_IDENT, IDENT_VALUE);
    reg_rd_chk(8'h40, 16'h0000);
    reg_wr(ADDR_SEQ_LAUNCH, 16'h0113);
    chk({15'h0000, b_run}, 16'h0000);
    reg_wr(ADDR_SEQ_CTRL, 16'h0113);
    reg_wr(ADDR_STEP_TARGET, 16'h00ff);
    reg_wr(ADDR_STEP_PAYLOAD, 16'h0000);
    reg_wr(ADDR_SEQ_LAUNCH, 16'h0113);
    wait_step_b(t);
    chk({8'h00, t}, 16'h005e);
    wait_idle_b(20000);
    reg_rd_chk(ADDR_SEQ_STATUS, 16'h0000);
    reg_rd_chk(ADDR_SEQ_LAUNCH, 16'h0013);
    reg_wr(ADDR_SEQ_LAUNCH, 16'h0113);
    reg_wr(ADDR_SEQ_LAUNCH, 16'h0200);
    wait_idle_b(2);
    reg_wr(ADDR_SEQ_LAUNCH, 16'h0313);
    chk({15'h0000, b_run}, 16'h0000);
    reg_wr(ADDR_IDENT, 16'h0000);
    reg_rd_chk(ADDR_SEQ_CTRL, SEQ_CTRL_RST);
    reg_wr(ADDR_SEQ_CTRL, 16'h0100);
    reg_wr(ADDR_SEQ_LAUNCH, 16'h0113);
    wait_step_b(t);
    chk({8'h00, t}, 16'h005a);
    wait_idle_b(20000);
    reg_wr(ADDR_SEQ_CTRL, 16'h0111);
    reg_wr(ADDR_STEP_TARGET, 16'h1212);
    reg_wr(ADDR_STEP_PAYLOAD, 16'h4055);
    reg_rd_chk(ADDR_STEP_TARGET, 16'h1212);
    reg_rd_chk(ADDR_STEP_PAYLOAD, 16'h4055);
    reg_wr(ADDR_SEQ_LAUNCH, 16'h0111);
    wait_step_b(t);
    chk({8'h00, t}, 16'h0012);
    chk({12'h000, b_lsb}, 16'h0002);
    chk({13'h0000, b_wid}, 16'h0001);
    chk({8'h00, b_val}, 16'h0055);
    wait_idle_b(10);
    // Shutdown before any start-up is refused: host stays ready, clock off
    @(negedge i_ref_clk);
    cmd_valid = 1'b1;
    cmd = CMD_SHUTDOWN;
    @(negedge i_ref_clk);
    cmd_valid = 1'b0;
    chk({15'h0000, h_ready}, 16'h0001);
    chk({15'h0000, bus_a.mclk_run}, 16'h0000);
    host_cmd(CMD_STARTUP, 30000);
    chk(a_dac, 16'h0000);
    chk({15'h0000, h_gate}, 16'h0001);
    chk({15'h0000, a_run}, 16'h0000);
    host_cmd(CMD_SHUTDOWN, 30000);
    chk({15'h0000, a_run}, 16'h0000);
    @(negedge i_ref_clk);
    chk({15'h0000, h_gate}, 16'h0000);
    host_cmd(CMD_FAST_STARTUP, 30000);
    chk({15'h0000, h_gate}, 16'h0001);
    chk({15'h0000, a_run}, 16'h0000);
    sup_c = 1'b0;
    repeat (3) @(negedge i_ref_clk);
    chk({15'h0000, a_por_n}, 16'h0000);
    sup_c = 1'b1;
    complete_run();
  end
endmodule : rqs_tb_top
`default_nettype wire
